// File: supply_supervisor_pkg.sv
package supply_supervisor_pkg;

   // ----------------------------------------
   // timebase
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
   localparam int unsigned CNT_W = 28;

   // ----------------------------------------
   // reset hold times, milliseconds
   // ----------------------------------------
   localparam int unsigned HOLD_A_MS = 1;
   localparam int unsigned HOLD_B_MS = 20;
   localparam int unsigned HOLD_C_MS = 140;
   localparam int unsigned HOLD_D_MS = 1120;
   localparam logic [CNT_W-1:0] HOLD_A_CYC = CNT_W'(HOLD_A_MS * CYC_PER_MS);
   localparam logic [CNT_W-1:0] HOLD_B_CYC = CNT_W'(HOLD_B_MS * CYC_PER_MS);
   localparam logic [CNT_W-1:0] HOLD_C_CYC = CNT_W'(HOLD_C_MS * CYC_PER_MS);
   localparam logic [CNT_W-1:0] HOLD_D_CYC = CNT_W'(HOLD_D_MS * CYC_PER_MS);
   localparam logic [1:0] HOLD_SEL_A = 2'h0;
   localparam logic [1:0] HOLD_SEL_B = 2'h1;
   localparam logic [1:0] HOLD_SEL_C = 2'h2;
   localparam logic [1:0] HOLD_SEL_D = 2'h3;

   // ----------------------------------------
   // watchdog periods
   // ----------------------------------------
   localparam int unsigned WD_NORMAL_US = 4300;
   localparam int unsigned WD_EXTENDED_MS = 17900;
   localparam logic [CNT_W-1:0] WD_NORMAL_CYC = CNT_W'(WD_NORMAL_US * CYC_PER_US);
   localparam logic [CNT_W-1:0] WD_EXTENDED_CYC = CNT_W'(WD_EXTENDED_MS * CYC_PER_MS);

   localparam logic [CNT_W-1:0] CNT_ZERO = 28'h0000000;
   localparam logic [CNT_W-1:0] CNT_ONE = 28'h0000001;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_ASSERT = 2'h0,
      ST_HOLD = 2'h1,
      ST_RUN = 2'h3
   } sup_state_t;

   typedef struct packed {
      logic rst_hi;
      logic rst_lo_n;
      logic odh_o;
      logic odh_oe_n;
      logic odl_o;
      logic odl_oe_n;
      logic bid_o;
      logic bid_oe_n;
   } rst_pins_t;

   localparam rst_pins_t PINS_ASSERTED = '{rst_hi: 1'h1, rst_lo_n: 1'h0, odh_o: 1'h0, odh_oe_n: 1'h1,
                                           odl_o: 1'h0, odl_oe_n: 1'h0, bid_o: 1'h0, bid_oe_n: 1'h0};

endpackage

// File: supply_supervisor_reset_logic.sv
`timescale 1ns/1ps
// Summary of operation
// R1: reset when kick input shows no edge for a whole watchdog period
// R2: processor must toggle the kick input at least once every watchdog period
// R3: reset while either undervoltage sense input reports low voltage
// R4: reset while the overvoltage sense input reports high voltage
// R5: reset while manual reset input is low
// R6: all reset outputs stay asserted one hold time after last source clears
// R7: active-high push-pull output high in reset, low after hold time
// R8: active-high open-drain output released high in reset and through hold
// R9: active-low push-pull output low in reset and hold, then high
// R10: active-low open-drain output pulled low in reset and through hold
// R11: bidirectional active-low output low in reset, returns high after hold
// R12: hold time selectable 1, 20, 140 or 1120 ms, default 1120
// R13: watchdog select picks normal or extended, longer, watchdog period
// R14: watchdog periods span 4.3 ms to 17.9 s
// R15: reset condition is the OR of all sources
// R16: watchdog counter restarts on every kick edge and while reset asserted
module supply_supervisor_reset_logic #(
   parameter logic [supply_supervisor_pkg::CNT_W-1:0] HOLD_A_CYC = supply_supervisor_pkg::HOLD_A_CYC,
   parameter logic [supply_supervisor_pkg::CNT_W-1:0] HOLD_B_CYC = supply_supervisor_pkg::HOLD_B_CYC,
   parameter logic [supply_supervisor_pkg::CNT_W-1:0] HOLD_C_CYC = supply_supervisor_pkg::HOLD_C_CYC,
   parameter logic [supply_supervisor_pkg::CNT_W-1:0] HOLD_D_CYC = supply_supervisor_pkg::HOLD_D_CYC,
   parameter logic [supply_supervisor_pkg::CNT_W-1:0] WD_NORMAL_CYC = supply_supervisor_pkg::WD_NORMAL_CYC,
   parameter logic [supply_supervisor_pkg::CNT_W-1:0] WD_EXTENDED_CYC = supply_supervisor_pkg::WD_EXTENDED_CYC
) (
   // clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // configuration
   input wire logic [1:0] HOLD_SEL,
   input wire logic WATCHDOG_EXT_SEL,
   input wire logic WATCHDOG_EN,
   // reset sources
   input wire logic WATCHDOG_KICK_IN,
   input wire logic UNDERVOLT_SENSE_A,
   input wire logic UNDERVOLT_SENSE_B,
   input wire logic OVERVOLT_SENSE,
   input wire logic MANUAL_RESET_N,
   // push-pull outputs
   output logic RST_OUT,
   output logic RST_N_OUT,
   // open-drain outputs
   output logic OPENDRAIN_RST_OUT_O,
   output logic OPENDRAIN_RST_OUT_OE_N,
   output logic OPENDRAIN_RST_N_O,
   output logic OPENDRAIN_RST_N_OE_N,
   // bidirectional output
   input wire logic BIDIR_RST_N_I,
   output logic BIDIR_RST_N_O,
   output logic BIDIR_RST_N_OE_N
);

   // ----------------------------------------
   // selections
   // ----------------------------------------
   function automatic logic [supply_supervisor_pkg::CNT_W-1:0] hold_decode(input logic [1:0] sel);
      case (sel)
         supply_supervisor_pkg::HOLD_SEL_A: hold_decode = HOLD_A_CYC;
         supply_supervisor_pkg::HOLD_SEL_B: hold_decode = HOLD_B_CYC;
         supply_supervisor_pkg::HOLD_SEL_C: hold_decode = HOLD_C_CYC;
         default: hold_decode = HOLD_D_CYC;
      endcase
   endfunction

   logic [supply_supervisor_pkg::CNT_W-1:0] hold_limit;
   logic [supply_supervisor_pkg::CNT_W-1:0] wd_limit;
   assign hold_limit = hold_decode(HOLD_SEL); // R12
   assign wd_limit = WATCHDOG_EXT_SEL ? WD_EXTENDED_CYC : WD_NORMAL_CYC; // R13 R14

   // ----------------------------------------
   // watchdog
   // ----------------------------------------
   logic kick_prev_reg;
   logic kick_prev_next;
   logic [supply_supervisor_pkg::CNT_W-1:0] wd_cnt_reg;
   logic [supply_supervisor_pkg::CNT_W-1:0] wd_cnt_next;
   logic kick_edge;
   logic wd_exp;
   supply_supervisor_pkg::rst_pins_t pins_reg;
   supply_supervisor_pkg::rst_pins_t pins_next;

   always_comb begin
      kick_prev_next = WATCHDOG_KICK_IN;
      kick_edge = WATCHDOG_KICK_IN ^ kick_prev_reg;
      wd_exp = WATCHDOG_EN && !kick_edge && !pins_reg.rst_hi &&
               (wd_cnt_reg >= wd_limit - supply_supervisor_pkg::CNT_ONE); // R1
      if (kick_edge || pins_reg.rst_hi || !WATCHDOG_EN || wd_exp) begin
         wd_cnt_next = supply_supervisor_pkg::CNT_ZERO; // R16
      end else begin
         wd_cnt_next = wd_cnt_reg + supply_supervisor_pkg::CNT_ONE;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         kick_prev_reg <= 1'h0;
         wd_cnt_reg <= supply_supervisor_pkg::CNT_ZERO;
      end else begin
         kick_prev_reg <= kick_prev_next;
         wd_cnt_reg <= wd_cnt_next;
      end
   end

   // ----------------------------------------
   // reset sequencing and pins
   // ----------------------------------------
   supply_supervisor_pkg::sup_state_t state_reg;
   supply_supervisor_pkg::sup_state_t state_next;
   logic [supply_supervisor_pkg::CNT_W-1:0] hold_cnt_reg;
   logic [supply_supervisor_pkg::CNT_W-1:0] hold_cnt_next;
   logic cond;
   logic asserted;

   assign cond = wd_exp || UNDERVOLT_SENSE_A || UNDERVOLT_SENSE_B || OVERVOLT_SENSE || !MANUAL_RESET_N; // R15 R3 R4 R5

   always_comb begin
      state_next = state_reg;
      hold_cnt_next = hold_cnt_reg;
      case (state_reg)
         supply_supervisor_pkg::ST_ASSERT: begin
            hold_cnt_next = supply_supervisor_pkg::CNT_ZERO;
            if (!cond) begin
               state_next = supply_supervisor_pkg::ST_HOLD;
            end
         end
         supply_supervisor_pkg::ST_HOLD: begin
            if (cond) begin
               state_next = supply_supervisor_pkg::ST_ASSERT;
               hold_cnt_next = supply_supervisor_pkg::CNT_ZERO;
            end else if (hold_cnt_reg >= hold_limit - supply_supervisor_pkg::CNT_ONE) begin
               state_next = supply_supervisor_pkg::ST_RUN; // R6
               hold_cnt_next = supply_supervisor_pkg::CNT_ZERO;
            end else begin
               hold_cnt_next = hold_cnt_reg + supply_supervisor_pkg::CNT_ONE;
            end
         end
         supply_supervisor_pkg::ST_RUN: begin
            if (cond) begin
               state_next = supply_supervisor_pkg::ST_ASSERT;
            end
         end
         default: begin
            state_next = supply_supervisor_pkg::ST_ASSERT;
            hold_cnt_next = supply_supervisor_pkg::CNT_ZERO;
         end
      endcase
      asserted = (state_next != supply_supervisor_pkg::ST_RUN);
      pins_next.rst_hi = asserted; // R7
      pins_next.rst_lo_n = !asserted; // R9
      pins_next.odh_o = 1'h0;
      pins_next.odh_oe_n = asserted; // R8
      pins_next.odl_o = 1'h0;
      pins_next.odl_oe_n = !asserted; // R10
      pins_next.bid_o = !asserted; // R11
      pins_next.bid_oe_n = !(asserted || pins_reg.rst_hi); // R11
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         state_reg <= supply_supervisor_pkg::ST_HOLD;
         hold_cnt_reg <= supply_supervisor_pkg::CNT_ZERO;
         pins_reg <= supply_supervisor_pkg::PINS_ASSERTED;
      end else begin
         state_reg <= state_next;
         hold_cnt_reg <= hold_cnt_next;
         pins_reg <= pins_next;
      end
   end

   assign RST_OUT = pins_reg.rst_hi;
   assign RST_N_OUT = pins_reg.rst_lo_n;
   assign OPENDRAIN_RST_OUT_O = pins_reg.odh_o;
   assign OPENDRAIN_RST_OUT_OE_N = pins_reg.odh_oe_n;
   assign OPENDRAIN_RST_N_O = pins_reg.odl_o;
   assign OPENDRAIN_RST_N_OE_N = pins_reg.odl_oe_n;
   assign BIDIR_RST_N_O = pins_reg.bid_o;
   assign BIDIR_RST_N_OE_N = pins_reg.bid_oe_n;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   chk_wd_expiry: assert property (wd_exp |=> RST_OUT ##1 wd_cnt_reg == supply_supervisor_pkg::CNT_ZERO) // R1
      else $error("watchdog expiry did not assert reset");
   chk_undervolt_src: assert property ((UNDERVOLT_SENSE_A || UNDERVOLT_SENSE_B) |=> RST_OUT && !RST_N_OUT) // R3
      else $error("undervoltage did not assert reset");
   chk_overvolt_src: assert property (OVERVOLT_SENSE |=> RST_OUT && !OPENDRAIN_RST_N_OE_N) // R4
      else $error("overvoltage did not assert reset");
   chk_manual_src: assert property (!MANUAL_RESET_N [*2] |=> RST_OUT && $past(RST_OUT)) // R5
      else $error("manual reset did not hold reset");
   chk_hold_release: assert property ($fell(RST_OUT) |-> $past(state_reg) == supply_supervisor_pkg::ST_HOLD &&
      $past(hold_cnt_reg) >= $past(hold_limit) - supply_supervisor_pkg::CNT_ONE && !$past(cond)) // R6 R12
      else $error("reset released before hold time");
   chk_hold_keeps: assert property (state_reg == supply_supervisor_pkg::ST_HOLD &&
      hold_cnt_reg < hold_limit - supply_supervisor_pkg::CNT_ONE |=> RST_OUT) // R6
      else $error("reset dropped during hold");
   chk_push_pull_pair: assert property (RST_OUT != RST_N_OUT) // R7 R9
      else $error("push-pull outputs disagree");
   chk_opendrain_pair: assert property (OPENDRAIN_RST_OUT_OE_N == RST_OUT && OPENDRAIN_RST_N_OE_N == !RST_OUT &&
      !OPENDRAIN_RST_OUT_O && !OPENDRAIN_RST_N_O) // R8 R10
      else $error("open-drain outputs disagree with reset");
   chk_bidir_drive: assert property (RST_OUT |-> !BIDIR_RST_N_OE_N && !BIDIR_RST_N_O) // R11
      else $error("bidirectional output not low in reset");
   chk_bidir_pullup: assert property ($fell(RST_OUT) |-> BIDIR_RST_N_O && !BIDIR_RST_N_OE_N ##1 (BIDIR_RST_N_OE_N || RST_OUT)) // R11
      else $error("bidirectional pull-up pulse wrong");
   chk_wd_restart: assert property ((kick_edge || RST_OUT) |=> wd_cnt_reg == supply_supervisor_pkg::CNT_ZERO) // R16
      else $error("watchdog counter not restarted");
   chk_cond_merge: assert property (cond |=> state_reg == supply_supervisor_pkg::ST_ASSERT) // R15
      else $error("reset source not merged");
   chk_wd_disabled: assert property (!WATCHDOG_EN |=> wd_cnt_reg == supply_supervisor_pkg::CNT_ZERO) // R1
      else $error("disabled watchdog still counting");
   chk_run_released: assert property (state_reg == supply_supervisor_pkg::ST_RUN &&
      $past(state_reg) == supply_supervisor_pkg::ST_RUN |-> !RST_OUT && BIDIR_RST_N_OE_N) // R7 R11
      else $error("reset outputs not released in run");

   cov_wd_expiry: cover property (wd_exp);
   cov_manual_cycle: cover property (!MANUAL_RESET_N ##1 MANUAL_RESET_N);
   cov_release: cover property ($fell(RST_OUT));
   cov_hold_abort: cover property (state_reg == supply_supervisor_pkg::ST_HOLD && cond);
   cov_ext_expiry: cover property (wd_exp && WATCHDOG_EXT_SEL);

endmodule

// File: cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// supervised processor: kicks while out of reset
// ----------------------------------------
module cpu_model (
   // clock
   input wire logic clk,
   // reset seen on the bidirectional wire
   input wire logic rst_n_in,
   // kick control
   input wire logic kick_en,
   input wire logic [7:0] gap,
   output logic kick
);
   logic [7:0] cnt_reg;
   initial begin
      kick = 1'b0;
      cnt_reg = 8'h00;
   end
   // toggle once every gap cycles, silent in reset
   always @(posedge clk) begin
      if (!rst_n_in || !kick_en) begin
         cnt_reg <= 8'h00;
      end else if (cnt_reg >= gap - 8'h01) begin
         cnt_reg <= 8'h00;
         kick <= #1 ~kick;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
   localparam int HOLD[4] = '{int'(supply_supervisor_pkg::HOLD_A_CYC), 8, 12, 16};
   localparam int WN = 20;
   localparam int WE = 40;
   logic clk, srst, wd_ext, wd_en, kick, kick_en;
   logic [1:0] hold_sel;
   logic [3:0] src;
   logic [7:0] gap;
   logic rst_out, rst_n_out, odh_o, odh_oe_n, odl_o, odl_oe_n, bid_o, bid_oe_n;
   wire logic odh_w = odh_oe_n ? 1'h1 : odh_o;
   wire logic odl_w = odl_oe_n ? 1'h1 : odl_o;
   wire logic bid_w = bid_oe_n ? 1'h1 : bid_o;
   int err_total, n_tests, n, hits;
   supply_supervisor_reset_logic #(.HOLD_B_CYC(28'h8), .HOLD_C_CYC(28'hc),
      .HOLD_D_CYC(28'h10), .WD_NORMAL_CYC(28'h14), .WD_EXTENDED_CYC(28'h28)) DUT (
      .CLK(clk), .SRST(srst), .HOLD_SEL(hold_sel), .WATCHDOG_EXT_SEL(wd_ext), .WATCHDOG_EN(wd_en),
      .WATCHDOG_KICK_IN(kick), .UNDERVOLT_SENSE_A(src[0]), .UNDERVOLT_SENSE_B(src[1]),
      .OVERVOLT_SENSE(src[2]), .MANUAL_RESET_N(~src[3]), .RST_OUT(rst_out), .RST_N_OUT(rst_n_out),
      .OPENDRAIN_RST_OUT_O(odh_o), .OPENDRAIN_RST_OUT_OE_N(odh_oe_n), .OPENDRAIN_RST_N_O(odl_o),
      .OPENDRAIN_RST_N_OE_N(odl_oe_n), .BIDIR_RST_N_I(bid_w), .BIDIR_RST_N_O(bid_o),
      .BIDIR_RST_N_OE_N(bid_oe_n));
   cpu_model partner (.clk(clk), .rst_n_in(bid_w), .kick_en(kick_en), .gap(gap), .kick(kick));
   // ----------------------------------------
   // clock and helpers
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t pins got %b exp %b", $time, got, exp);
      end
   endtask
   task automatic chk_count(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         err_total++;
         $display("ERROR %0t count got %0d exp %0d", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] pins();
      return {rst_out, rst_n_out, odh_w, odl_w, odh_o, odl_o, bid_w, bid_oe_n};
   endfunction
   function automatic logic [7:0] exp_pins(input logic a);
      return {a, ~a, a, ~a, 1'h0, 1'h0, ~a, ~a};
   endfunction
   task automatic wait_flip(input logic v, output int k);
      k = 0;
      while (rst_out === v && k < 12000) begin
         step();
         k++;
      end
   endtask
   task automatic count_hits(input int cycles);
      hits = 0;
      repeat (cycles) begin
         step();
         if (rst_out !== 1'b0) hits++;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_power();
      chk_bits(pins(), exp_pins(1'b1));
      wait_flip(1'b1, n);
      chk_count(n, HOLD[3]);
      chk_bits(pins(), 8'h52);
      step();
      chk_bits(pins(), exp_pins(1'b0));
   endtask
   task automatic t_sources();
      for (int i = 0; i < 4; i++) begin
         hold_sel = 2'(i);
         src = 4'h1 << i;
         step();
         step();
         chk_bits(pins(), exp_pins(1'b1));
         src = 4'h0;
         wait_flip(1'b1, n);
         chk_count(n, HOLD[i] + 1);
         step();
         chk_bits(pins(), exp_pins(1'b0));
      end
   endtask
   task automatic t_wd(input logic ext, input int w);
      wd_ext = ext;
      kick_en = 1'b0;
      src = 4'h8;
      step();
      src = 4'h0;
      wait_flip(1'b1, n);
      wait_flip(1'b0, n);
      chk_count(n, w);
      wait_flip(1'b1, n);
      kick_en = 1'b1;
      gap = 8'(w - 5);
      count_hits(3 * w);
      chk_count(hits, 0);
      wd_en = 1'b0;
      kick_en = 1'b0;
      count_hits(3 * w);
      chk_count(hits, 0);
      wd_en = 1'b1;
   endtask
   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic give_verdict();
      $display("tests %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #(100 * 20000);
      err_total++;
      $display("ERROR %0t run did not finish", $time);
      give_verdict();
   end
   initial begin
      err_total = 0;
      n_tests = 0;
      srst = 1'b1;
      hold_sel = 2'h3;
      wd_ext = 1'b0;
      wd_en = 1'b1;
      src = 4'h0;
      kick_en = 1'b1;
      gap = 8'h0f;
      repeat (5) step();
      srst = 1'b0;
      t_power();
      t_sources();
      t_wd(1'b0, WN);
      t_wd(1'b1, WE);
      give_verdict();
   end
endmodule
